// >>> logic/csr_pkg.sv
// Purpose: Shared constants and carriers for the select/reset host controller
// Assumes: 200 MHz clock_in, AXI4-Lite register access
// Notes: Offsets are byte addresses of 32-bit words
package csr_pkg;
  localparam int unsigned CLK_PERIOD_PS = 5000;
  localparam int unsigned STD_RESET_MIN_NS = 100;
  localparam int unsigned LV_RESET_MIN_NS = 500;
  localparam int unsigned LV_RECOVERY_NS = 500;
  localparam int unsigned STD_RESET_CYC = (STD_RESET_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned LV_RESET_CYC = (LV_RESET_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned LV_RECOVERY_CYC = (LV_RECOVERY_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned CNT_W = 8;

  localparam logic [3:0] OFF_CTRL = 4'h0;
  localparam logic [3:0] OFF_STATUS = 4'h4;
  localparam logic [3:0] OFF_PULSE = 4'h8;

  localparam int unsigned CTRL_SELECT = 0;
  localparam int unsigned CTRL_VARIANT_LV = 1;
  localparam int unsigned CTRL_RST_POL_HIGH = 2;
  localparam int unsigned CTRL_PIN_IS_DECODE = 3;
  localparam int unsigned CTRL_DECODE_VAL = 4;
  localparam int unsigned CTRL_W = 5;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 5'h00;

  localparam int unsigned ST_RESET_ASSERTED = 0;
  localparam int unsigned ST_RECOVERING = 1;
  localparam int unsigned ST_READY = 2;
  localparam int unsigned ST_POWERDOWN = 3;
  localparam int unsigned ST_PIN = 4;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    CSR_IDLE,
    CSR_HOLD,
    CSR_RECOVER,
    CSR_RUN
  } csr_state_e;

  // First member is the top bit, so the list runs from bit 4 down to bit 0
  typedef struct packed {
    logic decode_val;
    logic pin_is_decode;
    logic rst_pol_high;
    logic variant_lv;
    logic select;
  } csr_ctrl_s;
endpackage

// >>> logic/csr_timer.sv
// Purpose: Down-counter timing a reset hold or recovery interval
// Assumes: Load and count share one clock
// Notes: done_out is high while the count is zero
`timescale 1ns/1ps
module csr_timer #(
  parameter int unsigned W = csr_pkg::CNT_W
) (
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic load_in,
  input wire logic [W-1:0] value_in,
  output logic done_out
);
  logic [W-1:0] count_r;

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      count_r <= '0;
    end else if (load_in) begin
      count_r <= value_in;
    end else if (count_r != '0) begin
      count_r <= count_r - W'(1);
    end
  end

  assign done_out = (count_r == '0);
endmodule

// >>> logic/csr_host.sv
// Purpose: Host-side driver of the device select/decode pin and reset line
// Assumes: AXI4-Lite slave for software; device pins synchronous to clock_in
// Notes: Reset pulse and recovery timing enforced before ready is reported
//
// Overview of operation
// [RULE_01] Select low keeps the device operating normally.
// [RULE_02] Select high puts the device in power-down.
// [RULE_03] In decode mode the pin carries an extra decoder input value.
// [RULE_04] In decode mode the device never powers down through the pin.
// [RULE_05] Power-down floats bus pins; port pins keep, float or drive high.
// [RULE_06] Push-pull second-port selects drive high in power-down.
// [RULE_07] Open-drain second-port selects float in power-down.
// [RULE_08] Third-port input pins stay inputs in power-down.
// [RULE_09] Push-pull third-port selects drive high in power-down.
// [RULE_10] Internal selects forced inactive in power-down.
// [RULE_11] Power-down leaves all I/O-space registers unchanged.
// [RULE_12] Device reset acts asynchronously.
// [RULE_13] Standard variant: hold reset at least 100 ns.
// [RULE_14] Standard variant is usable right after reset release.
// [RULE_15] Standard variant reset polarity is selectable.
// [RULE_16] Low-voltage variant: hold reset at least 500 ns.
// [RULE_17] Low-voltage variant needs 500 ns more after release.
// [RULE_18] Low-voltage reset is active low only; host inverts.
// [RULE_19] Host makes no memory access before the device is active.
// [RULE_20] Latched inputs capture on trailing address strobe edge.
// [RULE_21] Page register clears on every chip reset.
// [RULE_22] Driving select low returns device from power-down.
`timescale 1ns/1ps
module csr_host #(
  parameter int unsigned STD_HOLD = csr_pkg::STD_RESET_CYC,
  parameter int unsigned LV_HOLD = csr_pkg::LV_RESET_CYC,
  parameter int unsigned LV_RECOVER = csr_pkg::LV_RECOVERY_CYC
) (
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic [3:0] s_awaddr_in,
  input wire logic s_awvalid_in,
  output logic s_awready_out,
  input wire logic [31:0] s_wdata_in,
  input wire logic [3:0] s_wstrb_in,
  input wire logic s_wvalid_in,
  output logic s_wready_out,
  output logic [1:0] s_bresp_out,
  output logic s_bvalid_out,
  input wire logic s_bready_in,
  input wire logic [3:0] s_araddr_in,
  input wire logic s_arvalid_in,
  output logic s_arready_out,
  output logic [31:0] s_rdata_out,
  output logic [1:0] s_rresp_out,
  output logic s_rvalid_out,
  input wire logic s_rready_in,
  output logic select_pin_out,
  output logic device_reset_pin_out,
  output logic device_ready_out
);
  logic aw_seen_r;
  logic w_seen_r;
  logic [3:0] awaddr_r;
  logic [31:0] wdata_r;
  logic wstrb0_r;
  logic [4:0] ctrl_r;
  csr_pkg::csr_ctrl_s ctrl_v;
  csr_pkg::csr_state_e state_r;
  logic pulse_req_r;
  logic do_write;
  logic timer_load;
  logic [csr_pkg::CNT_W-1:0] timer_value;
  logic timer_done;
  logic reset_active;
  logic powerdown;
  logic pin_quiet_r;

  assign ctrl_v = csr_pkg::csr_ctrl_s'(ctrl_r);

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write path
  assign s_awready_out = !aw_seen_r && !s_bvalid_out;
  assign s_wready_out = !w_seen_r && !s_bvalid_out;
  assign do_write = aw_seen_r && w_seen_r && !s_bvalid_out;

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      aw_seen_r <= 1'b0;
      w_seen_r <= 1'b0;
      awaddr_r <= 4'h0;
      wdata_r <= 32'h0;
      wstrb0_r <= 1'b0;
    end else begin
      if (s_awvalid_in && s_awready_out) begin
        aw_seen_r <= 1'b1;
        awaddr_r <= s_awaddr_in;
      end
      if (s_wvalid_in && s_wready_out) begin
        w_seen_r <= 1'b1;
        wdata_r <= s_wdata_in;
        wstrb0_r <= s_wstrb_in[0];
      end
      if (do_write) begin
        aw_seen_r <= 1'b0;
        w_seen_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      s_bvalid_out <= 1'b0;
      s_bresp_out <= csr_pkg::RESP_OKAY;
    end else if (do_write) begin
      s_bvalid_out <= 1'b1;
      s_bresp_out <= (awaddr_r == csr_pkg::OFF_CTRL || awaddr_r == csr_pkg::OFF_PULSE)
                     ? csr_pkg::RESP_OKAY : csr_pkg::RESP_SLVERR;
    end else if (s_bready_in) begin
      s_bvalid_out <= 1'b0;
    end
  end

  // Control word; only low byte lane carries fields
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      ctrl_r <= csr_pkg::CTRL_RESET;
    end else if (do_write && wstrb0_r && awaddr_r == csr_pkg::OFF_CTRL) begin
      ctrl_r <= wdata_r[csr_pkg::CTRL_W-1:0];
    end
  end

  // Pulse request set by write, cleared when the hold starts
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      pulse_req_r <= 1'b0;
    end else if (do_write && wstrb0_r && awaddr_r == csr_pkg::OFF_PULSE && wdata_r[0]) begin
      pulse_req_r <= 1'b1;
    end else if (state_r == csr_pkg::CSR_HOLD) begin
      pulse_req_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite read path
  assign s_arready_out = !s_rvalid_out;

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      s_rvalid_out <= 1'b0;
      s_rdata_out <= 32'h0;
      s_rresp_out <= csr_pkg::RESP_OKAY;
    end else if (s_arvalid_in && s_arready_out) begin
      s_rvalid_out <= 1'b1;
      s_rresp_out <= csr_pkg::RESP_OKAY;
      unique case (s_araddr_in)
        csr_pkg::OFF_CTRL: s_rdata_out <= {27'h0, ctrl_r};
        csr_pkg::OFF_STATUS: s_rdata_out <= {27'h0, select_pin_out, powerdown, device_ready_out,
                                             state_r == csr_pkg::CSR_RECOVER, reset_active};
        csr_pkg::OFF_PULSE: s_rdata_out <= 32'h0;
        default: begin
          s_rdata_out <= 32'h0;
          s_rresp_out <= csr_pkg::RESP_SLVERR;
        end
      endcase
    end else if (s_rready_in) begin
      s_rvalid_out <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Reset sequencer; host reset always starts a full device reset
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      state_r <= csr_pkg::CSR_IDLE;
    end else begin
      unique case (state_r)
        csr_pkg::CSR_IDLE: state_r <= csr_pkg::CSR_HOLD;
        csr_pkg::CSR_HOLD: begin
          // Recovery load shares this edge; waiting on it would stall the hold
          if (timer_done) begin
            state_r <= ctrl_v.variant_lv ? csr_pkg::CSR_RECOVER : csr_pkg::CSR_RUN; // see [RULE_14]
          end
        end
        csr_pkg::CSR_RECOVER: begin
          if (timer_done && !timer_load) begin
            state_r <= csr_pkg::CSR_RUN; // see [RULE_17]
          end
        end
        csr_pkg::CSR_RUN: begin
          if (pulse_req_r) begin
            state_r <= csr_pkg::CSR_IDLE;
          end
        end
      endcase
    end
  end

  // Hold and recovery lengths, loaded on state entry
  assign timer_load = (state_r == csr_pkg::CSR_IDLE) ||
                      (state_r == csr_pkg::CSR_HOLD && timer_done && ctrl_v.variant_lv);
  always_comb begin
    if (state_r == csr_pkg::CSR_IDLE) begin
      timer_value = ctrl_v.variant_lv ? csr_pkg::CNT_W'(LV_HOLD) : csr_pkg::CNT_W'(STD_HOLD); // see [RULE_13] [RULE_16]
    end else begin
      timer_value = csr_pkg::CNT_W'(LV_RECOVER);
    end
  end

  csr_timer #(
    .W(csr_pkg::CNT_W)
  ) u_timer (
    .clock_in(clock_in),
    .rst_in(rst_in),
    .load_in(timer_load),
    .value_in(timer_value),
    .done_out(timer_done)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Device pins
  assign reset_active = (state_r == csr_pkg::CSR_IDLE) || (state_r == csr_pkg::CSR_HOLD);
  assign powerdown = !ctrl_v.pin_is_decode && ctrl_v.select; // see [RULE_02] [RULE_04]

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      device_reset_pin_out <= 1'b0;
    end else if (ctrl_v.variant_lv || !ctrl_v.rst_pol_high) begin
      device_reset_pin_out <= !reset_active; // Active low; see [RULE_18] [RULE_15]
    end else begin
      device_reset_pin_out <= reset_active; // see [RULE_15]
    end
  end

  // Decode mode carries software value; select mode drives low unless power-down
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      select_pin_out <= 1'b0;
    end else if (ctrl_v.pin_is_decode) begin
      select_pin_out <= ctrl_v.decode_val; // see [RULE_03]
    end else begin
      select_pin_out <= ctrl_v.select; // see [RULE_01] [RULE_22]
    end
  end

  // Memory accesses gated until device is out of reset and not powered down
  // Pins lag the sequencer by one register; ready waits for the pins themselves
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      pin_quiet_r <= 1'b0;
    end else begin
      pin_quiet_r <= !reset_active && !powerdown;
    end
  end
  assign device_ready_out = (state_r == csr_pkg::CSR_RUN) && !powerdown && pin_quiet_r; // see [RULE_19]

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  logic [csr_pkg::CNT_W-1:0] low_cnt_r;
  always_ff @(posedge clock_in) begin
    if (rst_in || !reset_active) begin
      low_cnt_r <= '0;
    end else if (low_cnt_r != '1) begin
      low_cnt_r <= low_cnt_r + csr_pkg::CNT_W'(1);
    end
  end

  a_hold_long_enough: assert property (@(posedge clock_in) disable iff (rst_in) // see [RULE_13] [RULE_16]
    $fell(reset_active) |-> $past(low_cnt_r) >=
      (ctrl_v.variant_lv ? csr_pkg::CNT_W'(LV_HOLD) : csr_pkg::CNT_W'(STD_HOLD)))
    else $error("device reset hold too short");
  a_lv_recovery: assert property (@(posedge clock_in) disable iff (rst_in) // see [RULE_17]
    $fell(reset_active) && ctrl_v.variant_lv |-> !device_ready_out [*8])
    else $error("ready during low-voltage recovery");
  a_std_ready: assert property (@(posedge clock_in) disable iff (rst_in) // see [RULE_14]
    $fell(reset_active) && !ctrl_v.variant_lv && !powerdown && !pulse_req_r |=> device_ready_out)
    else $error("standard variant not ready after release");
  a_lv_polarity: assert property (@(posedge clock_in) disable iff (rst_in) // see [RULE_18]
    ##1 $past(ctrl_v.variant_lv) && $past(reset_active) |-> !device_reset_pin_out)
    else $error("low-voltage reset not active low");
  a_high_polarity: assert property (@(posedge clock_in) disable iff (rst_in) // see [RULE_15]
    ##1 $past(!ctrl_v.variant_lv && ctrl_v.rst_pol_high) |-> device_reset_pin_out == $past(reset_active))
    else $error("high-polarity reset wrong");
  a_no_early_access: assert property (@(posedge clock_in) disable iff (rst_in) // see [RULE_19]
    device_ready_out |-> !reset_active && state_r == csr_pkg::CSR_RUN)
    else $error("ready while device in reset");
  a_decode_no_pd: assert property (@(posedge clock_in) disable iff (rst_in) // see [RULE_04]
    ctrl_v.pin_is_decode |-> !powerdown)
    else $error("power-down in decode mode");
  a_select_follows: assert property (@(posedge clock_in) disable iff (rst_in) // see [RULE_02] [RULE_22]
    !ctrl_v.pin_is_decode ##1 !$past(ctrl_v.pin_is_decode) |-> select_pin_out == $past(ctrl_v.select))
    else $error("select pin not following control");
  a_decode_value: assert property (@(posedge clock_in) disable iff (rst_in) // see [RULE_03]
    ##1 $past(ctrl_v.pin_is_decode) |-> select_pin_out == $past(ctrl_v.decode_val))
    else $error("decode value not driven");

  c_lv_cycle: cover property (@(posedge clock_in) disable iff (rst_in)
    ctrl_v.variant_lv && state_r == csr_pkg::CSR_RECOVER ##[1:300] device_ready_out);
  c_pulse: cover property (@(posedge clock_in) disable iff (rst_in) pulse_req_r ##[1:200] reset_active);
  c_powerdown: cover property (@(posedge clock_in) disable iff (rst_in) powerdown ##[1:50] !powerdown);
endmodule

// >>> bench/csr_dev_model.sv
// Purpose: Behavioural device seen only through its select and reset pins
// Assumes: Config inputs mirror the CTRL value last written by the bench
// Notes: Clockless like the real part; widths measured in real time
`timescale 1ns/1ps
module csr_dev_model (
  input wire logic select_in,
  input wire logic reset_pin_in,
  input wire logic lv_in,
  input wire logic pol_high_in,
  input wire logic decode_in,
  output logic in_reset_out,
  output logic powerdown_out,
  output logic width_err_out,
  output logic decode_term_out,
  output logic [3:0] page_out
);
  realtime t_on = 0.0;
  logic [3:0] page_r = 4'h0;
  realtime t_off = 0.0;
  initial width_err_out = 1'b0;
  ////////////////////////////////////////////////////////////////////////////////
  // Low-voltage part ignores the polarity choice
  assign in_reset_out = (lv_in || !pol_high_in) ? !reset_pin_in : reset_pin_in;
  // Level acts at once, no clock involved
  always @(in_reset_out) begin
    if (in_reset_out === 1'b1) begin
      t_on = $realtime;
    end else if (in_reset_out === 1'b0) begin
      t_off = $realtime;
      // Zero-width skew between pin and config mirror is not a pulse
      if (t_off - t_on > 1.0 && t_off - t_on < (lv_in ? 500.0 : 100.0)) width_err_out = 1'b1;
    end
  end
  // Page register survives power-down; any reset clears it
  always @(posedge in_reset_out) page_r = 4'h0;
  assign page_out = page_r;
  // Extra decoder input taken transparently; no address strobe is wired here
  assign decode_term_out = decode_in && select_in;
  // Powered down: bus and port pins float or park, selects inactive
  // Same state parks third-port pins and internal selects
  // Decode mode keeps the part enabled whatever the pin does
  assign powerdown_out = !in_reset_out && !decode_in && select_in;
endmodule

// >>> bench/csr_host_tb_top.sv
// Purpose: Self-checking bench for the select/reset host controller
// Assumes: Full-length hold and recovery counts; run stays short
// Notes: Outputs sampled on the falling edge where they are settled
`timescale 1ns/1ps
module csr_host_tb_top;
  localparam logic [31:0] SEL = 32'h1 << csr_pkg::CTRL_SELECT;
  localparam logic [31:0] LV = 32'h1 << csr_pkg::CTRL_VARIANT_LV;
  localparam logic [31:0] POL = 32'h1 << csr_pkg::CTRL_RST_POL_HIGH;
  localparam logic [31:0] DEC = 32'h1 << csr_pkg::CTRL_PIN_IS_DECODE;
  localparam logic [31:0] DV = 32'h1 << csr_pkg::CTRL_DECODE_VAL;
  localparam logic [31:0] RDY = 32'h1 << csr_pkg::ST_READY;
  localparam logic [31:0] PD = 32'h1 << csr_pkg::ST_POWERDOWN;
  localparam logic [31:0] PIN = 32'h1 << csr_pkg::ST_PIN;
  logic clock_in = 1'b0;
  logic rst_in = 1'b1;
  logic [3:0] awaddr = 4'h0;
  logic [3:0] araddr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, sel_pin, rst_pin, dev_rdy, m_rst, m_pd, m_werr;
  logic m_dt;
  logic [3:0] m_pg;
  logic [1:0] bresp, rresp, r;
  logic [31:0] rdata, d;
  logic [31:0] ctrl_m = 32'h0;
  int fails = 0;
  int n_compared = 0;
  int cyc = 0;
  int hold_c = 0, last_hold = 0, rec_c = 0, early = 0;
  ////////////////////////////////////////////////////////////////////////////////
  csr_host #(.STD_HOLD(csr_pkg::STD_RESET_CYC), .LV_HOLD(csr_pkg::LV_RESET_CYC),
    .LV_RECOVER(csr_pkg::LV_RECOVERY_CYC)) dut_u (.clock_in(clock_in), .rst_in(rst_in),
    .s_awaddr_in(awaddr), .s_awvalid_in(awvalid), .s_awready_out(awready), .s_wdata_in(wdata),
    .s_wstrb_in(4'hF), .s_wvalid_in(wvalid), .s_wready_out(wready), .s_bresp_out(bresp),
    .s_bvalid_out(bvalid), .s_bready_in(bready), .s_araddr_in(araddr), .s_arvalid_in(arvalid),
    .s_arready_out(arready), .s_rdata_out(rdata), .s_rresp_out(rresp), .s_rvalid_out(rvalid),
    .s_rready_in(rready), .select_pin_out(sel_pin), .device_reset_pin_out(rst_pin), .device_ready_out(dev_rdy));
  csr_dev_model mdl_u (.select_in(sel_pin), .reset_pin_in(rst_pin), .lv_in(ctrl_m[csr_pkg::CTRL_VARIANT_LV]),
    .pol_high_in(ctrl_m[csr_pkg::CTRL_RST_POL_HIGH]), .decode_in(ctrl_m[csr_pkg::CTRL_PIN_IS_DECODE]),
    .in_reset_out(m_rst), .powerdown_out(m_pd), .width_err_out(m_werr), .decode_term_out(m_dt), .page_out(m_pg));
  initial forever #2.5 clock_in = ~clock_in;
  ////////////////////////////////////////////////////////////////////////////////
  // Hold and recovery lengths in cycles, and any early ready
  always @(negedge clock_in) begin
    if (m_rst === 1'b1) begin
      hold_c <= hold_c + 1;
      rec_c <= 0;
    end else begin
      if (hold_c != 0) last_hold <= hold_c;
      hold_c <= 0;
      if (dev_rdy !== 1'b1) rec_c <= rec_c + 1;
    end
    if (dev_rdy === 1'b1 && m_rst === 1'b1) early <= early + 1;
  end
  always @(posedge clock_in) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails++;
      final_report();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] v, output logic [1:0] rs);
    logic pa, pw, ta, tw, hb;
    @(posedge clock_in);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    {pa, pw, hb} = 3'h6;
    while (!hb) begin
      @(negedge clock_in);
      ta = pa && awready;
      tw = pw && wready;
      hb = !pa && !pw && bvalid;
      rs = bresp;
      @(posedge clock_in);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      pa = pa && !ta;
      pw = pw && !tw;
    end
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] v, output logic [1:0] rs);
    logic pa, ta, hv;
    @(posedge clock_in);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    {pa, hv} = 2'h2;
    while (!hv) begin
      @(negedge clock_in);
      ta = pa && arready;
      hv = !pa && rvalid;
      v = rdata;
      rs = rresp;
      @(posedge clock_in);
      if (ta) arvalid <= 1'b0;
      pa = pa && !ta;
    end
    rready <= 1'b0;
  endtask
  task automatic setc(input logic [31:0] v);
    wr(csr_pkg::OFF_CTRL, v, r);
    ctrl_m = v;
    chk("ctrl write resp", csr_pkg::RESP_OKAY, r);
    @(negedge clock_in);
  endtask
  task automatic st(input string nm, input logic [31:0] e);
    rd(csr_pkg::OFF_STATUS, d, r);
    chk(nm, e, d);
  endtask
  task automatic wait_rdy();
    while (dev_rdy !== 1'b1) @(negedge clock_in);
    @(negedge clock_in);
  endtask
  // Reset must be seen by the model before the pin level is judged
  task automatic pulse(input logic exp_pin);
    wr(csr_pkg::OFF_PULSE, 32'h1, r);
    while (m_rst !== 1'b1) @(negedge clock_in);
    chk("reset pin level", exp_pin, rst_pin);
    chk("ready in reset", 32'h0, dev_rdy);
    wait_rdy();
  endtask
  task automatic final_report();
    $display("Comparisons %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (10) @(posedge clock_in);
    rst_in <= 1'b0;
    rd(csr_pkg::OFF_CTRL, d, r);
    chk("ctrl reset", {27'h0, csr_pkg::CTRL_RESET}, d);
    wait_rdy();
    chk("std hold", 32'h1, last_hold >= csr_pkg::STD_RESET_CYC);
    chk("std recovery", 32'h1, rec_c <= 2);
    st("status ready", RDY);
    $display("reset test done");
    setc(SEL);
    chk("select pin", 32'h1, sel_pin);
    chk("model powerdown", 32'h1, m_pd);
    chk("ready in powerdown", 32'h0, dev_rdy);
    chk("page in powerdown", 32'h0, m_pg);
    st("status powerdown", PD | PIN);
    setc(32'h0);
    chk("select pin", 32'h0, sel_pin);
    st("status back", RDY);
    $display("powerdown test done");
    setc(DEC | DV);
    chk("decode pin", 32'h1, sel_pin);
    chk("decode term", 32'h1, m_dt);
    st("status decode", RDY | PIN);
    setc(DEC | DV | SEL);
    chk("ready decode", 32'h1, dev_rdy);
    chk("model powerdown", 32'h0, m_pd);
    setc(DEC);
    chk("decode pin", 32'h0, sel_pin);
    chk("decode term", 32'h0, m_dt);
    $display("decode test done");
    setc(POL);
    pulse(1'b1);
    chk("std hold", 32'h1, last_hold >= csr_pkg::STD_RESET_CYC);
    chk("std recovery", 32'h1, rec_c <= 2);
    setc(LV | POL);
    pulse(1'b0);
    chk("lv hold", 32'h1, last_hold >= csr_pkg::LV_RESET_CYC);
    chk("lv recovery", 32'h1, rec_c >= csr_pkg::LV_RECOVERY_CYC);
    chk("page after reset", 32'h0, m_pg);
    $display("reset pulse test done");
    wr(4'hC, 32'h1, r);
    chk("unmapped write", csr_pkg::RESP_SLVERR, r);
    rd(4'hC, d, r);
    chk("unmapped read", csr_pkg::RESP_SLVERR, r);
    wr(csr_pkg::OFF_STATUS, 32'h0, r);
    st("status read only", RDY);
    chk("width errors", 32'h0, m_werr);
    chk("early ready", 32'h0, early);
    $display("refusal test done");
    final_report();
  end
endmodule
